// ==== core/mtm_pkg.sv ====
// Package of constants and carrier types for the modulo timer.
package mtm_pkg;
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [1:0] MTM_OFS_STATUS = 2'h0;
	localparam logic [1:0] MTM_OFS_CLKCFG = 2'h1;
	localparam logic [1:0] MTM_OFS_COUNT = 2'h2;
	localparam logic [1:0] MTM_OFS_LIMIT = 2'h3;
	localparam int MTM_BIT_FLAG = 7;
	localparam int MTM_BIT_IRQ_EN = 6;
	localparam int MTM_BIT_CNT_RST = 5;
	localparam int MTM_BIT_HALT = 4;
	localparam int MTM_SRC_HI = 5;
	localparam int MTM_SRC_LO = 4;
	localparam int MTM_PS_HI = 3;
	localparam int MTM_PS_LO = 0;
	// ------------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------------
	localparam logic [7:0] MTM_RST_COUNT = 8'h00;
	localparam logic [7:0] MTM_RST_LIMIT = 8'h00;
	// Top of the 8-bit count, the wrap point while the limit is zero.
	localparam logic [7:0] MTM_COUNT_TOP = 8'hFF;
	localparam logic [3:0] MTM_RST_PS = 4'h0;
	localparam logic [3:0] MTM_PS_MAX = 4'h8;
	localparam logic [1:0] MTM_SRC_BUS = 2'h0;
	localparam logic [1:0] MTM_SRC_FIXED = 2'h1;
	localparam logic [1:0] MTM_SRC_PIN_FALL = 2'h2;
	localparam logic [1:0] MTM_SRC_PIN_RISE = 2'h3;
	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mtm_bus_req_s;
	typedef struct packed {
		logic [1:0] source_select;
		logic [3:0] prescale_select;
	} mtm_clk_cfg_s;
endpackage : mtm_pkg

// ==== core/mtm_pin_sync.sv ====
// Three-stage synchroniser and edge detector for the external timer clock pin.
`timescale 1ns/1ps
`default_nettype none
module mtm_pin_sync
	import mtm_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Raw pin.
	input wire logic ext_timer_clock_pin,
	// Edge pulses, one bus cycle each.
	output logic rise_pulse,
	output logic fall_pulse
);
	typedef struct packed {
		logic [2:0] sync;
		logic level;
	} mtm_sync_s;
	mtm_sync_s state_r;
	mtm_sync_s state_nxt;
	// Shift the pin in; the first stage feeds only the second.
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.sync = {state_r.sync[1:0], ext_timer_clock_pin};
		// The accepted level moves only once the second and third stages agree.
		if (state_r.sync[1] == state_r.sync[2])
			state_nxt.level = state_r.sync[2];
	end
	always_ff @(posedge clock)
	begin
		if (rst)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end
	// An edge counts once the second and third stages agree on a level unlike the last.
	// The pin must stay at or below a quarter of bus rate so each level is seen by both.
	// The accepted level resets low like an idle pin, so no false edge follows reset.
	assign rise_pulse = state_r.sync[1] & state_r.sync[2] & ~state_r.level;
	assign fall_pulse = ~state_r.sync[1] & ~state_r.sync[2] & state_r.level;
endmodule : mtm_pin_sync
`default_nettype wire

// ==== core/mtm_prescaler.sv ====
// Power-of-two prescaler that turns source edges into single-cycle count ticks.
`timescale 1ns/1ps
`default_nettype none
module mtm_prescaler
	import mtm_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Source edge and divide code.
	input wire logic src_edge,
	input wire logic [3:0] prescale_select,
	// Count tick, one bus cycle.
	output logic tick
);
	typedef struct packed {
		logic [7:0] div;
	} mtm_ps_s;
	mtm_ps_s state_r;
	mtm_ps_s state_nxt;
	logic [3:0] code;
	logic [8:0] carry;
	// Codes above the largest step saturate to divide by 256.
	assign code = (prescale_select > MTM_PS_MAX) ? MTM_PS_MAX : prescale_select;
	// Ripple carry chain: carry[k] marks the edge where the low k bits roll over.
	assign carry[0] = src_edge;
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_carry
			assign carry[i + 1] = carry[i] & state_r.div[i];
		end
	endgenerate
	// Divide by two to the code; the divider runs on, so rate changes keep the count.
	assign tick = carry[code];
	always_comb
	begin
		state_nxt = state_r;
		if (src_edge)
			state_nxt.div = state_r.div + 8'h01;
	end
	always_ff @(posedge clock)
	begin
		if (rst)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end
endmodule : mtm_prescaler
`default_nettype wire

// ==== core/mtm_modulo_timer.sv ====
// Top of the 8-bit modulo timer: registers, source selection and counter.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mtm_modulo_timer
	import mtm_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Register port.
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Clock sources.
	input wire logic fixed_freq_clock,
	input wire logic ext_timer_clock_pin,
	// Interrupt request.
	output logic overflow_irq
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] wrap_limit;
		logic overflow_flag;
		logic overflow_irq_enable;
		logic counter_halt;
		mtm_clk_cfg_s cfg;
		logic clear_armed;
		logic fixed_prev;
		logic [7:0] rdata;
	} mtm_state_s;
	mtm_state_s state_r;
	mtm_state_s state_nxt;
	mtm_bus_req_s req;
	logic pin_rise;
	logic pin_fall;
	logic fixed_rise;
	logic src_edge;
	logic tick;
	logic wrap;
	logic wr_status;
	logic wr_limit;
	logic rd_status;
	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign wr_status = req.wr && (req.addr == MTM_OFS_STATUS);
	assign wr_limit = req.wr && (req.addr == MTM_OFS_LIMIT);
	assign rd_status = req.rd && (req.addr == MTM_OFS_STATUS);
	// ------------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------------
	mtm_pin_sync u_pin_sync (
		.clock(clock),
		.rst(rst),
		.ext_timer_clock_pin(ext_timer_clock_pin),
		.rise_pulse(pin_rise),
		.fall_pulse(pin_fall)
	);
	// The fixed clock is assumed slow and bus-synchronous, so its rising edge is found directly.
	assign fixed_rise = fixed_freq_clock & ~state_r.fixed_prev;
	// Pick the prescaler input; bus clock gives an edge every cycle.
	always_comb
	begin
		case (state_r.cfg.source_select)
			MTM_SRC_BUS: src_edge = 1'b1;
			MTM_SRC_FIXED: src_edge = fixed_rise;
			MTM_SRC_PIN_FALL: src_edge = pin_fall;
			MTM_SRC_PIN_RISE: src_edge = pin_rise;
			default: src_edge = 1'b1;
		endcase
	end
	mtm_prescaler u_prescaler (
		.clock(clock),
		.rst(rst),
		.src_edge(src_edge),
		.prescale_select(state_r.cfg.prescale_select),
		.tick(tick)
	);
	// ------------------------------------------------------------------
	// Counter and register logic
	// ------------------------------------------------------------------
	// Wrap at the limit; a zero limit makes 8'hFF the wrap point.
	assign wrap = !state_r.counter_halt && tick &&
		((state_r.wrap_limit == MTM_RST_LIMIT) ? (state_r.count == MTM_COUNT_TOP)
			: (state_r.count == state_r.wrap_limit));
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.fixed_prev = fixed_freq_clock;
		// Counting: halted holds value, source or rate changes never clear it.
		if (!state_r.counter_halt && tick)
		begin
			if (wrap)
				state_nxt.count = 8'h00;
			else
				state_nxt.count = state_r.count + 8'h01;
		end
		// Reading status while the flag is set arms the two-step clear.
		if (rd_status && state_r.overflow_flag)
			state_nxt.clear_armed = 1'b1;
		if (wr_status)
		begin
			state_nxt.overflow_irq_enable = req.wdata[MTM_BIT_IRQ_EN];
			state_nxt.counter_halt = req.wdata[MTM_BIT_HALT];
			// Writing zero to the flag after an armed read clears it.
			if (!req.wdata[MTM_BIT_FLAG] && state_r.clear_armed)
				state_nxt.overflow_flag = 1'b0;
			state_nxt.clear_armed = 1'b0;
			// Reset strobe zeroes count and flag; a zero leaves the counter alone.
			if (req.wdata[MTM_BIT_CNT_RST])
			begin
				state_nxt.count = MTM_RST_COUNT;
				state_nxt.overflow_flag = 1'b0;
			end
		end
		if (req.wr && (req.addr == MTM_OFS_CLKCFG))
		begin
			state_nxt.cfg.source_select = req.wdata[MTM_SRC_HI:MTM_SRC_LO];
			state_nxt.cfg.prescale_select = req.wdata[MTM_PS_HI:MTM_PS_LO];
		end
		// Count register writes are ignored.
		// Limit write stores the limit, zeroes count and clears the flag.
		if (wr_limit)
		begin
			state_nxt.wrap_limit = req.wdata;
			state_nxt.count = MTM_RST_COUNT;
			state_nxt.overflow_flag = 1'b0;
			state_nxt.clear_armed = 1'b0;
		end
		// A new overflow sets the flag and cancels any pending clear; it wins over the two-step clear, but a limit write or reset strobe wins over it.
		if (wrap && !wr_limit && !(wr_status && req.wdata[MTM_BIT_CNT_RST]))
		begin
			state_nxt.overflow_flag = 1'b1;
			state_nxt.clear_armed = 1'b0;
		end
		// Read data for the cycle after the strobe; unmapped bits read zero.
		state_nxt.rdata = 8'h00;
		if (req.rd)
		begin
			case (req.addr)
				MTM_OFS_STATUS: state_nxt.rdata = {state_r.overflow_flag,
					state_r.overflow_irq_enable, 1'b0, state_r.counter_halt, 4'h0};
				MTM_OFS_CLKCFG: state_nxt.rdata = {2'b00, state_r.cfg.source_select,
					state_r.cfg.prescale_select};
				MTM_OFS_COUNT: state_nxt.rdata = state_r.count;
				MTM_OFS_LIMIT: state_nxt.rdata = state_r.wrap_limit;
				default: state_nxt.rdata = 8'h00;
			endcase
		end
	end
	// Register the state; reset halts the timer and clears everything else.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_r <= '0;
			state_r.counter_halt <= 1'b1;
			state_r.cfg.prescale_select <= MTM_RST_PS;
			state_r.count <= MTM_RST_COUNT;
			state_r.wrap_limit <= MTM_RST_LIMIT;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end
	// Interrupt follows the flag while enabled; software must clear the flag first.
	assign overflow_irq = state_r.overflow_irq_enable & state_r.overflow_flag;
	assign rdata = state_r.rdata;
endmodule : mtm_modulo_timer
`default_nettype wire

// ==== test/mtm_modulo_timer_assertions.sv ====
// Port-level checker for the modulo timer.
`timescale 1ns/1ps
`default_nettype none
module mtm_checker
	import mtm_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Register port and request.
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic overflow_irq
);
	// ------------------------------------------------------------
	// Port relations
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// A halted counter reset, then a count read two cycles on.
	sequence halt_clr_s;
		wr && addr == MTM_OFS_STATUS && wdata[5:4] == 2'b11;
	endsequence
	sequence cnt_rd_s;
		rd && addr == MTM_OFS_COUNT;
	endsequence
	status_zero_a: assert property (
		rd && addr == MTM_OFS_STATUS |=> rdata[5] == 1'b0 && rdata[3:0] == 4'h0)
		else $error("status reserved bits set");
	clkcfg_zero_a: assert property (
		rd && addr == MTM_OFS_CLKCFG |=> rdata[7:6] == 2'b00)
		else $error("clock config reserved bits set");
	irq_flag_a: assert property (
		rd && addr == MTM_OFS_STATUS && overflow_irq |=> rdata[7:6] == 2'b11)
		else $error("request without flag and enable");
	reset_quiet_a: assert property (
		$fell(rst) |-> !overflow_irq && rdata == 8'h00)
		else $error("request or data after reset");
	limit_clear_a: assert property (
		wr && addr == MTM_OFS_LIMIT |=> !overflow_irq)
		else $error("limit write left request");
	strobe_clear_a: assert property (
		wr && addr == MTM_OFS_STATUS && wdata[5] |=> !overflow_irq)
		else $error("counter reset left request");
	strobe_count_a: assert property (
		halt_clr_s ##2 cnt_rd_s |=> rdata == 8'h00)
		else $error("count not zero after reset strobe");
	irq_hold_a: assert property (
		overflow_irq && !wr |=> overflow_irq)
		else $error("request dropped without a write");
endmodule : mtm_checker
bind mtm_modulo_timer mtm_checker mtm_checker_inst (
	.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .overflow_irq(overflow_irq));
`default_nettype wire

// ==== test/mtm_modulo_timer_tb_top.sv ====
// Self-checking testbench for the modulo timer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module mtm_modulo_timer_tb_top
	import mtm_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fixed_freq_clock = 1'b0;
	logic ext_timer_clock_pin = 1'b0;
	wire logic [7:0] rdata;
	wire logic overflow_irq;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int seed = 32'h0000_f9f8;
	int n;
	int ex;
	mtm_modulo_timer mtm_modulo_timer_inst (.clock(clock), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fixed_freq_clock(fixed_freq_clock),
		.ext_timer_clock_pin(ext_timer_clock_pin), .overflow_irq(overflow_irq));
	// Clock at 20 MHz.
	always #25 clock = ~clock;
	// One-cycle write; the gap after it keeps strobes from being assigned twice.
	task automatic wr_t(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_t
	// One-cycle read, data compared in the following cycle only.
	task automatic rd_t(input logic [1:0] a, input logic [7:0] e, input string nm);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask : rd_t
	// Edges on both sources at bus/4, then time for the pin synchroniser.
	task automatic pulse_t(input int k);
		repeat (k)
		begin
			fixed_freq_clock <= 1'b1;
			ext_timer_clock_pin <= 1'b1;
			repeat (2) @(posedge clock);
			fixed_freq_clock <= 1'b0;
			ext_timer_clock_pin <= 1'b0;
			repeat (2) @(posedge clock);
		end
		repeat (6) @(posedge clock);
	endtask : pulse_t
	// Expected status byte; the strobe bit and the low nibble always read zero.
	function automatic logic [7:0] status_exp(input logic flag, input logic en, input logic halt);
		return {flag, en, 1'b0, halt, 4'h0};
	endfunction : status_exp
	// Expected count after some ticks from zero; a zero limit wraps past the top value.
	function automatic logic [7:0] count_exp(input int ticks, input logic [7:0] limit);
		int span;
		span = (limit == 8'h00) ? 256 : int'(limit) + 1;
		return 8'(ticks % span);
	endfunction : count_exp
	// Verdict and end of run.
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// A hang counts as a mismatch; the full run needs about 19000 cycles.
	always @(posedge clock)
	begin
		cyc++;
		if (cyc > 60000)
		begin
			bad_count++;
			stop_test();
		end
	end
	// Main sequence.
	initial
	begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd_t(MTM_OFS_STATUS, 8'h10, "status");
		rd_t(MTM_OFS_CLKCFG, 8'h00, "clkcfg");
		rd_t(MTM_OFS_LIMIT, 8'h00, "limit");
		wr_t(MTM_OFS_COUNT, 8'($random(seed)));
		rd_t(MTM_OFS_COUNT, 8'h00, "count");
		$display("reset test done");
		wr_t(MTM_OFS_CLKCFG, 8'h10);
		wr_t(MTM_OFS_STATUS, 8'h00);
		n = 3 + ($random(seed) & 15);
		pulse_t(n);
		wr_t(MTM_OFS_STATUS, 8'h10);
		pulse_t(5);
		rd_t(MTM_OFS_COUNT, 8'(n), "halted");
		wr_t(MTM_OFS_STATUS, 8'h00);
		pulse_t(4);
		rd_t(MTM_OFS_COUNT, 8'(n + 4), "resumed");
		wr_t(MTM_OFS_STATUS, 8'h30);
		rd_t(MTM_OFS_COUNT, 8'h00, "strobe");
		rd_t(MTM_OFS_STATUS, 8'h10, "strobe bit");
		$display("halt test done");
		wr_t(MTM_OFS_STATUS, 8'h00);
		ex = 0;
		// Any window of 2*d edges holds two ticks, whatever the divider phase.
		for (int k = 0; k < 16; k++)
		begin
			wr_t(MTM_OFS_CLKCFG, {2'b00, 2'(k % 3 + 1), 4'(k)});
			pulse_t(2 << (k > 8 ? 8 : k));
			ex += 2;
			rd_t(MTM_OFS_COUNT, 8'(ex), "scaled");
		end
		$display("prescale test done");
		wr_t(MTM_OFS_LIMIT, 8'h02);
		wr_t(MTM_OFS_CLKCFG, 8'h10);
		pulse_t(3);
		wr_t(MTM_OFS_STATUS, 8'h00);
		rd_t(MTM_OFS_STATUS, 8'h80, "unarmed");
		wr_t(MTM_OFS_STATUS, 8'h00);
		rd_t(MTM_OFS_STATUS, 8'h00, "cleared");
		pulse_t(3);
		rd_t(MTM_OFS_STATUS, 8'h80, "set");
		pulse_t(3);
		wr_t(MTM_OFS_STATUS, 8'h00);
		rd_t(MTM_OFS_STATUS, 8'h80, "kept");
		wr_t(MTM_OFS_STATUS, 8'h00);
		wr_t(MTM_OFS_STATUS, 8'h40);
		#1 `CHK("irq off", 1'b0, overflow_irq)
		pulse_t(3);
		#1 `CHK("irq on", 1'b1, overflow_irq)
		rd_t(MTM_OFS_STATUS, 8'hc0, "both");
		wr_t(MTM_OFS_LIMIT, 8'h05);
		#1 `CHK("irq limit", 1'b0, overflow_irq)
		rd_t(MTM_OFS_COUNT, 8'h00, "limit zero");
		pulse_t(6);
		#1 `CHK("irq wrap", 1'b1, overflow_irq)
		wr_t(MTM_OFS_STATUS, 8'h60);
		#1 `CHK("irq strobe", 1'b0, overflow_irq)
		$display("flag test done");
		// Bus clock at full rate with a zero limit: the count runs through the top value.
		wr_t(MTM_OFS_LIMIT, 8'h00);
		wr_t(MTM_OFS_STATUS, 8'h30);
		wr_t(MTM_OFS_CLKCFG, 8'h00);
		n = 254 + ($random(seed) & 7);
		wr_t(MTM_OFS_STATUS, 8'h00);
		repeat (n) @(posedge clock);
		wr_t(MTM_OFS_STATUS, 8'h10);
		rd_t(MTM_OFS_COUNT, count_exp(n + 2, 8'h00), "free run");
		rd_t(MTM_OFS_STATUS, status_exp(1'b1, 1'b0, 1'b1), "free flag");
		// Reset in mid-run brings every register back to its reset value.
		wr_t(MTM_OFS_LIMIT, 8'($random(seed)));
		wr_t(MTM_OFS_CLKCFG, 8'h3f);
		wr_t(MTM_OFS_STATUS, 8'h40);
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd_t(MTM_OFS_STATUS, status_exp(1'b0, 1'b0, 1'b1), "reset status");
		rd_t(MTM_OFS_CLKCFG, 8'h00, "reset clkcfg");
		rd_t(MTM_OFS_LIMIT, 8'h00, "reset limit");
		rd_t(MTM_OFS_COUNT, 8'h00, "reset count");
		$display("bus clock and reset test done");
		stop_test();
	end
endmodule : mtm_modulo_timer_tb_top
`default_nettype wire
